// File: pfh_pkg.sv
// package for the channel A input select, fast-settle and holdover bank
// assumes byte-wide registers at 16-bit addresses on the config port
package pfh_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int FREQ_W = 24;
   localparam int RATE_W = 12;
   localparam int STEP_W = 8;

   // register offsets
   localparam logic [15:0] OFF_IN_SEL = 16'h042A;
   localparam logic [15:0] OFF_FAST = 16'h042B;
   localparam logic [15:0] OFF_HOLD = 16'h042C;
   localparam logic [15:0] OFF_HLEN = 16'h042E;
   localparam logic [15:0] OFF_HDLY = 16'h042F;
   localparam logic [15:0] OFF_CNT0 = 16'h0432;
   localparam logic [15:0] OFF_CNT1 = 16'h0433;
   localparam logic [15:0] OFF_CNT2 = 16'h0434;

   // writable bit masks, reserved bits read as zero
   localparam logic [7:0] MSK_IN_SEL = 8'h07;
   localparam logic [7:0] MSK_FAST = 8'h03;
   localparam logic [7:0] MSK_HOLD = 8'hF9;
   localparam logic [7:0] MSK_HIST = 8'h1F;
   localparam logic [7:0] MSK_CNT = 8'hFF;

   // reset values
   localparam logic [7:0] RST_IN_SEL = 8'h00;
   localparam logic [7:0] RST_FAST = 8'h00;
   localparam logic [7:0] RST_HOLD = 8'h01;
   localparam logic [7:0] RST_HIST = 8'h00;
   localparam logic [7:0] RST_CNT = 8'h00;

   // field positions
   localparam int FAST_AUTO_BIT = 0;
   localparam int FAST_FORCE_BIT = 1;
   localparam int HOLD_EN_BIT = 0;
   localparam int HOLD_BYP_BIT = 3;
   localparam int HOLD_EXIT_BIT = 4;
   localparam int HOLD_RATE_LSB = 5;
   localparam logic [2:0] SEL_FIRST_RSVD = 3'h4;
   localparam logic [1:0] SEL_DEFAULT = 2'h0;

   // base ramp rates in units of 0.01 ppm/s, by code 0..7
   localparam logic [11:0] RATE_C0 = 12'h094;
   localparam logic [11:0] RATE_C1 = 12'h0DE;
   localparam logic [11:0] RATE_C2 = 12'h0FD;
   localparam logic [11:0] RATE_C3 = 12'h076;
   localparam logic [11:0] RATE_C4 = 12'h04A;
   localparam logic [11:0] RATE_C5 = 12'h1FA;
   localparam logic [11:0] RATE_C6 = 12'h3F4;
   localparam logic [11:0] RATE_C7 = 12'hFD0;

   // history time unit is 2/3 x 10^-7 s; one sample strobe per unit
   localparam int HIST_LEN_UNITS = 4;
   localparam int HIST_DEPTH = 32;

   typedef enum logic [1:0] {
      FS_NORMAL = 2'b00,
      FS_AUTO = 2'b01,
      FS_EXIT = 2'b10
   } pfh_fast_state_t;
endpackage

// File: pfh_history_avg.sv
// holdover history averager: delayed window of input frequency samples
// assumes one sample strobe per 2/3 x 10^-7 s history time unit
`timescale 1ns/1ps
module pfh_history_avg #(
   parameter int W = pfh_pkg::FREQ_W,
   parameter int DEPTH = pfh_pkg::HIST_DEPTH
) (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic sample_i, // one pulse per history time unit
   input wire logic [W-1:0] freq_i, // measured input frequency word
   input wire logic [4:0] len_i, // history window length code
   input wire logic [4:0] delay_i, // history window delay code
   input wire logic freeze_i, // holdover active, stop tracking
   output logic [W-1:0] avg_o, // running window average
   output logic [W-1:0] hold_freq_o // frequency used in holdover
);
   import pfh_pkg::*;

   logic [W-1:0] line_reg [DEPTH];
   logic [W-1:0] avg_reg;
   logic [W-1:0] hold_reg;
   logic freeze_d_reg;
   logic [4:0] tap;
   logic [4:0] shift;
   logic [W-1:0] delayed;
   logic signed [W:0] diff;
   logic signed [W:0] step;

   // delay is 2^N units, clamped to the depth of the line
   assign tap = (delay_i >= 5'd5) ? 5'(DEPTH - 1) : 5'(5'd1 << delay_i);
   assign delayed = line_reg[tap];
   // window of (2^N - 1) x 4 units gives a decay of about N + 2 bits
   assign shift = (len_i > 5'd20) ? 5'd22 : len_i + 5'd2;
   assign diff = $signed({1'b0, delayed}) - $signed({1'b0, avg_reg});
   assign step = diff >>> shift;

   // sample delay line, newest at index 0
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_line
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               line_reg[g] <= '0;
            end else if (sample_i && !freeze_i) begin
               line_reg[g] <= (g == 0) ? freq_i : line_reg[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   // average tracks only while out of holdover; captured on entry
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avg_reg <= '0;
         hold_reg <= '0;
         freeze_d_reg <= 1'b0;
      end else begin
         freeze_d_reg <= freeze_i;
         if (sample_i && !freeze_i) begin
            avg_reg <= W'($signed({1'b0, avg_reg}) + step);
         end
         if (freeze_i && !freeze_d_reg) begin
            hold_reg <= avg_reg;
         end
      end
   end

   assign avg_o = avg_reg;
   assign hold_freq_o = hold_reg;
endmodule

// File: pfh_ctrl.sv
// channel A input select, fast-settle and holdover control bank
// assumes a byte register port already decoded from the serial config port
// and lock, fault and frequency status inputs synchronous to clk_i
//
// Overview of operation
// - select field 2:0 picks input 0..3, default 0; codes 4-7 reserved
// - with register control low the select pins choose the input
// - fast-settle bit 0 enables automatic fast-settle, reset 0
// - fast-settle bit 1 forces fast-settle, reset 0
// - any active fast-settle selects the fast bandwidth set
// - auto and holdover exit: return to normal bandwidth once loss of lock clears
// - holdover control bit 0 enables holdover, reset 1
// - holdover bit 4 picks exit bandwidth: 0 fast, 1 normal
// - bits 7:5 give base ramp rate, scaled by step factor
// - window length is (2^N - 1) x 8/3 x 10^-7 s
// - holdover uses the averaged input frequency from the window
// - window delayed by 2^N x 2/3 x 10^-7 s into the past for N up to 4, else 31 units
`timescale 1ns/1ps
module pfh_ctrl #(
   parameter int FW = pfh_pkg::FREQ_W
) (
   input wire logic clk_i, // system clock, 20 MHz
   input wire logic rst_n_i, // async reset, active low
   input wire logic [pfh_pkg::ADDR_W-1:0] addr_i, // register address
   input wire logic [pfh_pkg::DATA_W-1:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   input wire logic register_select_control_i, // 1: register picks input
   input wire logic [1:0] pin_select_i, // input choice from pins
   input wire logic loss_of_lock_flag_i, // loop not locked
   input wire logic input_fault_i, // selected input invalid
   input wire logic [pfh_pkg::STEP_W-1:0] ramp_step_factor_i, // step adjust
   input wire logic sample_i, // history time unit strobe
   input wire logic [FW-1:0] freq_i, // measured input frequency
   output logic [pfh_pkg::DATA_W-1:0] rdata_o, // read data
   output logic [1:0] input_choice_o, // active input 0..3
   output logic use_fast_bw_o, // fast bandwidth set in use
   output logic holdover_active_o, // loop in holdover
   output logic ramp_bypass_o, // ramp bypass bit
   output logic [19:0] ramp_rate_o, // ramp rate, 0.01 ppm/s units
   output logic [23:0] holdover_cycle_total_o, // cycle count value
   output logic [FW-1:0] holdover_freq_o // frequency used in holdover
);
   import pfh_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // registers

   logic [7:0] sel_reg;
   logic [7:0] fast_reg;
   logic [7:0] hold_reg;
   logic [7:0] hlen_reg;
   logic [7:0] hdly_reg;
   logic [7:0] cnt0_reg;
   logic [7:0] cnt1_reg;
   logic [7:0] cnt2_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   pfh_fast_state_t fs_reg;
   pfh_fast_state_t fs_next;
   logic [1:0] choice_reg;
   logic [1:0] choice_next;
   logic fast_bw_reg;
   logic fast_next;
   logic hold_act_reg;
   logic hold_act_next;
   logic hold_prev_reg;
   logic [19:0] rate_reg;
   logic [19:0] rate_next;
   logic [23:0] count_reg;

   // decoded write strobes and fields
   logic wr_sel, wr_fast, wr_hold, wr_hlen, wr_hdly;
   logic wr_cnt0, wr_cnt1, wr_cnt2;
   logic auto_en, forced, hold_en, exit_normal, hold_fell;
   logic [2:0] rate_code;
   logic [11:0] base_rate;

   // true when the address matches the given offset
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   // base ramp rate by code
   function automatic logic [11:0] rate_lut(input logic [2:0] c);
      case (c)
         3'h0: rate_lut = RATE_C0;
         3'h1: rate_lut = RATE_C1;
         3'h2: rate_lut = RATE_C2;
         3'h3: rate_lut = RATE_C3;
         3'h4: rate_lut = RATE_C4;
         3'h5: rate_lut = RATE_C5;
         3'h6: rate_lut = RATE_C6;
         default: rate_lut = RATE_C7;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // address decode
   assign wr_sel = wr_i && hit(addr_i, OFF_IN_SEL);
   assign wr_fast = wr_i && hit(addr_i, OFF_FAST);
   assign wr_hold = wr_i && hit(addr_i, OFF_HOLD);
   assign wr_hlen = wr_i && hit(addr_i, OFF_HLEN);
   assign wr_hdly = wr_i && hit(addr_i, OFF_HDLY);
   assign wr_cnt0 = wr_i && hit(addr_i, OFF_CNT0);
   assign wr_cnt1 = wr_i && hit(addr_i, OFF_CNT1);
   assign wr_cnt2 = wr_i && hit(addr_i, OFF_CNT2);

   // register file, reserved bits masked to zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_reg <= RST_IN_SEL;
         fast_reg <= RST_FAST;
         hold_reg <= RST_HOLD;
         hlen_reg <= RST_HIST;
         hdly_reg <= RST_HIST;
         cnt0_reg <= RST_CNT;
         cnt1_reg <= RST_CNT;
         cnt2_reg <= RST_CNT;
      end else begin
         if (wr_sel) sel_reg <= wdata_i & MSK_IN_SEL;
         if (wr_fast) fast_reg <= wdata_i & MSK_FAST;
         if (wr_hold) hold_reg <= wdata_i & MSK_HOLD;
         if (wr_hlen) hlen_reg <= wdata_i & MSK_HIST;
         if (wr_hdly) hdly_reg <= wdata_i & MSK_HIST;
         if (wr_cnt0) cnt0_reg <= wdata_i & MSK_CNT;
         if (wr_cnt1) cnt1_reg <= wdata_i & MSK_CNT;
         if (wr_cnt2) cnt2_reg <= wdata_i & MSK_CNT;
      end
   end

   // read mux, unmapped addresses return zero
   always_comb begin
      rdata_next = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            OFF_IN_SEL: rdata_next = sel_reg;
            OFF_FAST: rdata_next = fast_reg;
            OFF_HOLD: rdata_next = hold_reg;
            OFF_HLEN: rdata_next = hlen_reg;
            OFF_HDLY: rdata_next = hdly_reg;
            OFF_CNT0: rdata_next = cnt0_reg;
            OFF_CNT1: rdata_next = cnt1_reg;
            OFF_CNT2: rdata_next = cnt2_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input selection; a reserved code keeps the current input
   always_comb begin
      choice_next = choice_reg;
      if (!register_select_control_i) begin
         choice_next = pin_select_i;
      end else if (sel_reg[2:0] < SEL_FIRST_RSVD) begin
         choice_next = sel_reg[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fields and holdover entry/exit
   assign auto_en = fast_reg[FAST_AUTO_BIT];
   assign forced = fast_reg[FAST_FORCE_BIT];
   assign hold_en = hold_reg[HOLD_EN_BIT];
   assign exit_normal = hold_reg[HOLD_EXIT_BIT];
   assign rate_code = hold_reg[7:HOLD_RATE_LSB];
   assign hold_act_next = hold_en && input_fault_i;
   assign hold_fell = hold_prev_reg && !hold_act_reg;
   assign base_rate = rate_lut(rate_code);
   assign rate_next = 20'(base_rate) * 20'(ramp_step_factor_i);

   // fast-settle state: auto entry on loss of lock, exit once locked
   always_comb begin
      fs_next = fs_reg;
      unique case (fs_reg)
         FS_NORMAL: begin
            if (hold_fell && !exit_normal) begin
               fs_next = FS_EXIT;
            end else if (auto_en && loss_of_lock_flag_i) begin
               fs_next = FS_AUTO;
            end
         end
         FS_AUTO: begin
            if (!auto_en || !loss_of_lock_flag_i) begin
               fs_next = FS_NORMAL;
            end
         end
         FS_EXIT: begin
            if (!loss_of_lock_flag_i || hold_act_reg) begin
               fs_next = FS_NORMAL;
            end
         end
         default: fs_next = FS_NORMAL;
      endcase
   end

   // fast bandwidth whenever forced or any fast-settle state is active
   assign fast_next = forced || (fs_next != FS_NORMAL);

   // state and output flops
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fs_reg <= FS_NORMAL;
         choice_reg <= SEL_DEFAULT;
         fast_bw_reg <= 1'b0;
         hold_act_reg <= 1'b0;
         hold_prev_reg <= 1'b0;
         rate_reg <= '0;
         count_reg <= '0;
         rdata_reg <= 8'h00;
      end else begin
         fs_reg <= fs_next;
         choice_reg <= choice_next;
         fast_bw_reg <= fast_next;
         hold_act_reg <= hold_act_next;
         hold_prev_reg <= hold_act_reg;
         rate_reg <= rate_next;
         count_reg <= {cnt2_reg, cnt1_reg, cnt0_reg};
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // history averager, window length and delay from the registers
   pfh_history_avg #(
      .W(FW),
      .DEPTH(HIST_DEPTH)
   ) u_hist (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sample_i(sample_i),
      .freq_i(freq_i),
      .len_i(hlen_reg[4:0]),
      .delay_i(hdly_reg[4:0]),
      .freeze_i(hold_act_reg),
      .avg_o(),
      .hold_freq_o(holdover_freq_o)
   );

   // outputs
   assign rdata_o = rdata_reg;
   assign input_choice_o = choice_reg;
   assign use_fast_bw_o = fast_bw_reg;
   assign holdover_active_o = hold_act_reg;
   assign ramp_bypass_o = hold_reg[HOLD_BYP_BIT];
   assign ramp_rate_o = rate_reg;
   assign holdover_cycle_total_o = count_reg;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_hold_exit;
      holdover_active_o ##1 (!holdover_active_o && !exit_normal && !forced);
   endsequence

   sequence s_auto_locked;
      (fs_reg == FS_AUTO) && auto_en && !forced && !loss_of_lock_flag_i;
   endsequence

   a_sel_pins: assert property (
      !register_select_control_i |=> input_choice_o == $past(pin_select_i))
      else $error("pin select not followed");
   a_sel_manual: assert property (
      register_select_control_i && sel_reg[2:0] < SEL_FIRST_RSVD
      |=> input_choice_o == $past(sel_reg[1:0]))
      else $error("register select not followed");
   a_sel_reserved: assert property (
      register_select_control_i && sel_reg[2] |=> $stable(input_choice_o))
      else $error("reserved select changed input");
   a_force_fast: assert property (
      forced |=> use_fast_bw_o)
      else $error("forced fast-settle not applied");
   a_auto_entry: assert property (
      fs_reg == FS_NORMAL && auto_en && loss_of_lock_flag_i && !hold_fell
      |=> use_fast_bw_o && fs_reg == FS_AUTO)
      else $error("auto fast-settle not entered");
   a_auto_exit: assert property (
      s_auto_locked |=> !use_fast_bw_o && fs_reg == FS_NORMAL)
      else $error("auto fast-settle did not end on lock");
   a_exit_bw: assert property (
      s_hold_exit ##0 (fs_reg == FS_NORMAL) |=> use_fast_bw_o)
      else $error("holdover exit did not use fast bandwidth");
   a_hold_gate: assert property (
      !hold_en |=> !holdover_active_o)
      else $error("holdover entered while disabled");
   a_ramp_rate: assert property (
      rate_code == 3'h7
      |=> ramp_rate_o == 20'(RATE_C7) * 20'($past(ramp_step_factor_i)))
      else $error("ramp rate wrong for top code");
   a_read_fast: assert property (
      rd_i && addr_i == OFF_FAST && !wr_i
      |=> rdata_o == ($past(fast_reg) & MSK_FAST))
      else $error("fast-settle readback wrong");
   a_count_bytes: assert property (
      wr_cnt2 ##1 !wr_i |=> holdover_cycle_total_o[23:16] == $past(wdata_i, 2))
      else $error("cycle count high byte misplaced");
endmodule

// File: pfh_ctrl_test.sv
// self-checking testbench for the channel A select, fast-settle and
// holdover bank; drives the byte register port and status pins itself
`timescale 1ns/1ps
module pfh_ctrl_test;
   import pfh_pkg::*;
   logic clk_i, rst_n_i, wr_i, rd_i, reg_ctl, lock_lost, fault, sample_i;
   logic [15:0] addr_i;
   logic [7:0] wdata_i, rdata_o, step;
   logic [1:0] pins, choice;
   logic [23:0] freq_i, total, hfreq;
   logic fast, hold, byp;
   logic [19:0] rate;
   int n_fail, n_tests;
   // register table: offset, reset value, readable mask; last four unmapped
   logic [15:0] offs [12] = '{OFF_IN_SEL, OFF_FAST, OFF_HOLD, OFF_HLEN,
      OFF_HDLY, OFF_CNT0, OFF_CNT1, OFF_CNT2, 16'h042D, 16'h0430, 16'h0431,
      16'h0435};
   logic [7:0] rsts [12] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] msks [12] = '{8'h07, 8'h03, 8'hF9, 8'h1F, 8'h1F, 8'hFF,
      8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   // base ramp rates per code in 0.01 ppm/s
   logic [11:0] rates [8] = '{12'h094, 12'h0DE, 12'h0FD, 12'h076, 12'h04A,
      12'h1FA, 12'h3F4, 12'hFD0};

   ////////////////////////////////////////////////////////////////////////
   // device under test
   pfh_ctrl dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .register_select_control_i(reg_ctl), .pin_select_i(pins),
      .loss_of_lock_flag_i(lock_lost), .input_fault_i(fault),
      .ramp_step_factor_i(step), .sample_i(sample_i), .freq_i(freq_i),
      .rdata_o(rdata_o), .input_choice_o(choice), .use_fast_bw_o(fast),
      .holdover_active_o(hold), .ramp_bypass_o(byp), .ramp_rate_o(rate),
      .holdover_cycle_total_o(total), .holdover_freq_o(hfreq)
   );

   ////////////////////////////////////////////////////////////////////////
   // compare, report and bus tasks
   task automatic end_of_test();
      $display("counts: %0d compared, %0d mismatched", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t read=%h expected=%h", $time, got, exp);
      end
   endtask

   task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t out=%h expected=%h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe, launched and dropped on falling edges
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge clk_i);
      wr_i = 1'b0;
   endtask

   // read data is registered, so it is looked at one cycle later
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clk_i);
      rd_i = 1'b0;
      chk_reg(rdata_o, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic pulse(input int n);
      repeat (n) begin
         sample_i = 1'b1;
         @(negedge clk_i);
         sample_i = 1'b0;
         @(negedge clk_i);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   initial begin
      repeat (100000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_n_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 16'h0000;
      wdata_i = 8'h00;
      reg_ctl = 1'b1;
      pins = 2'h0;
      lock_lost = 1'b0;
      fault = 1'b0;
      step = 8'h01;
      sample_i = 1'b0;
      freq_i = 24'h000000;
      n_fail = 0;
      n_tests = 0;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1'b1;
      for (int i = 0; i < 12; i++) begin
         rd(offs[i], rsts[i]);
      end
      chk_out({22'h0, choice}, 24'h0);
      $display("test reset_values done");
      // all ones written, reserved bits and unmapped places read zero
      for (int i = 0; i < 12; i++) begin
         wr(offs[i], 8'hFF);
         rd(offs[i], msks[i]);
      end
      $display("test write_masks done");
      // register choice, a reserved code, then pin choice
      wr(OFF_HOLD, 8'h09);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_IN_SEL, 8'(i));
         cyc(3);
         chk_out({22'h0, choice}, 24'(i));
      end
      wr(OFF_IN_SEL, 8'h05);
      cyc(3);
      chk_out({22'h0, choice}, 24'h3);
      reg_ctl = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         pins = 2'(i);
         cyc(3);
         chk_out({22'h0, choice}, 24'(i));
      end
      reg_ctl = 1'b1;
      wr(OFF_IN_SEL, 8'h02);
      cyc(3);
      chk_out({22'h0, choice}, 24'h2);
      $display("test input_select done");
      // automatic and forced fast-settle against the lock flag
      wr(OFF_FAST, 8'h00);
      lock_lost = 1'b1;
      cyc(3);
      chk_out({23'h0, fast}, 24'h0);
      wr(OFF_FAST, 8'h01);
      cyc(3);
      chk_out({23'h0, fast}, 24'h1);
      lock_lost = 1'b0;
      cyc(3);
      chk_out({23'h0, fast}, 24'h0);
      wr(OFF_FAST, 8'h02);
      cyc(3);
      chk_out({23'h0, fast}, 24'h1);
      wr(OFF_FAST, 8'h00);
      cyc(3);
      chk_out({23'h0, fast}, 24'h0);
      $display("test fast_settle done");
      // holdover entry and exit with both exit bandwidth choices
      lock_lost = 1'b1;
      fault = 1'b1;
      cyc(3);
      chk_out({23'h0, hold}, 24'h1);
      fault = 1'b0;
      cyc(3);
      chk_out({22'h0, hold, fast}, 24'h1);
      lock_lost = 1'b0;
      cyc(3);
      chk_out({23'h0, fast}, 24'h0);
      wr(OFF_HOLD, 8'h19);
      lock_lost = 1'b1;
      fault = 1'b1;
      cyc(3);
      fault = 1'b0;
      cyc(3);
      chk_out({22'h0, hold, fast}, 24'h0);
      lock_lost = 1'b0;
      wr(OFF_HOLD, 8'h08);
      fault = 1'b1;
      cyc(3);
      chk_out({23'h0, hold}, 24'h0);
      fault = 1'b0;
      $display("test holdover done");
      // every ramp code at the largest step factor
      step = 8'hFF;
      for (int i = 0; i < 8; i++) begin
         wr(OFF_HOLD, {3'(i), 5'h09});
         cyc(3);
         chk_out({4'h0, rate}, 24'(rates[i]) * 24'd255);
      end
      chk_out({23'h0, byp}, 24'h1);
      $display("test ramp_rate done");
      wr(OFF_CNT0, 8'h56);
      wr(OFF_CNT1, 8'h34);
      wr(OFF_CNT2, 8'hA2);
      cyc(3);
      chk_out(total, 24'hA23456);
      $display("test cycle_count done");
      // steady input, then holdover must keep the averaged value
      wr(OFF_HOLD, 8'h09);
      wr(OFF_HLEN, 8'h00);
      wr(OFF_HDLY, 8'h00);
      freq_i = 24'h123456;
      pulse(100);
      // a recent step inside a 16-unit delay must not reach the average
      wr(OFF_HDLY, 8'h04);
      freq_i = 24'h000100;
      pulse(8);
      fault = 1'b1;
      cyc(3);
      chk_out({23'h0, (24'h123456 - hfreq) < 24'h8}, 24'h1);
      pulse(50);
      chk_out({23'h0, (24'h123456 - hfreq) < 24'h8}, 24'h1);
      fault = 1'b0;
      // short window with the shortest, 1-unit delay settles on the new input
      wr(OFF_HDLY, 8'h00);
      pulse(100);
      fault = 1'b1;
      cyc(3);
      chk_out(hfreq, 24'h000100);
      fault = 1'b0;
      // a 60-unit window moves only a little after 8 new samples
      wr(OFF_HLEN, 8'h04);
      freq_i = 24'h010100;
      pulse(8);
      fault = 1'b1;
      cyc(3);
      chk_out({23'h0, hfreq > 24'h100 && hfreq < 24'h2500}, 24'h1);
      fault = 1'b0;
      $display("test history done");
      // reset in mid-run restores registers and outputs
      rst_n_i = 1'b0;
      cyc(3);
      rst_n_i = 1'b1;
      rd(OFF_HOLD, 8'h01);
      rd(OFF_FAST, 8'h00);
      rd(OFF_IN_SEL, 8'h00);
      chk_out({22'h0, choice}, 24'h0);
      chk_out(total, 24'h0);
      chk_out(hfreq, 24'h0);
      $display("test mid_reset done");
      end_of_test();
   end
endmodule
